/* hdl/sensor_regs_defines.vh */
// Register offsets, field positions, reset values and timing constants
`ifndef SENSOR_REGS_DEFINES_VH
`define SENSOR_REGS_DEFINES_VH

// Register pointer values (4-bit pointer space)
`define PTR_RESULT        4'h0
`define PTR_UNLOCK        4'h4
`define PTR_SCRATCH_A     4'h5
`define PTR_SCRATCH_B     4'h6
`define PTR_SCRATCH_C     4'h7
`define PTR_SCRATCH_D     4'h8
`define PTR_PART_ID       4'hF

// Unlock register fields
`define UNLOCK_BIT        15
`define BUSY_BIT          14

// Reset values
`define RST_UNLOCK        1'b0
`define RST_SCRATCH_C     16'h0000
`define RST_RESULT        16'h0000

// Part identifier; value is arbitrary
`define PART_ID_VALUE     16'h5A01

// Bus protocol constants
`define GEN_CALL_ADDR     8'h00
`define GEN_CALL_RESET    8'h06

// Averaging select codes
`define AVG_NONE          2'b00
`define AVG_8             2'b01
`define AVG_32            2'b10
`define AVG_64            2'b11

// Nonvolatile programming time and derived cycle count
`define CLK_PERIOD_NS     50
`define NV_PROG_NS        7000
`define NV_PROG_CYCLES    (`NV_PROG_NS / `CLK_PERIOD_NS)

`endif

/* hdl/twowire_target.v */
// Two-wire bus target engine: start/stop, address, pointer, word transfers
`include "sensor_regs_defines.vh"

module twowire_target (
  // Clock and reset
  input  wire        clock,
  input  wire        rst_n,
  // Bus pins
  input  wire        scl,
  input  wire        sda_in,
  output reg         sda_oe,
  // Own address
  input  wire [6:0]  target_addr,
  // Register side
  output reg  [3:0]  ptr,
  output reg         wr_stb,
  output reg  [15:0] wr_word,
  input  wire [15:0] rd_data,
  output reg         rd_stb,
  output reg         gc_stb
);

  // Engine states
  localparam S_IDLE = 3'd0;
  localparam S_RX   = 3'd1;
  localparam S_ACK  = 3'd2;
  localparam S_TX   = 3'd3;
  localparam S_MACK = 3'd4;

  reg [2:0]  state;      // Engine state
  reg        scl_q;      // Previous clock line sample
  reg        sda_q;      // Previous data line sample
  reg [7:0]  shift;      // Byte shifter
  reg [3:0]  bit_cnt;    // Bits moved in current byte
  reg [2:0]  byte_no;    // Byte index in frame, saturates at 4
  reg        rw;         // Frame direction, 1 = read
  reg        gc_mode;    // Frame addressed to general call
  reg [7:0]  msb;        // Held upper write byte
  reg [15:0] rd_word;    // Word latched for a read
  reg        tx_lsb;     // Next read byte is the lower one

  wire scl_rise = scl & ~scl_q;
  wire scl_fall = ~scl & scl_q;
  // Data edges while clock stays high frame the transfer
  wire start_c  = scl & scl_q & sda_q & ~sda_in;
  wire stop_c   = scl & scl_q & ~sda_q & sda_in;

  // Bus engine; the device only answers, never drives the clock line
  always @(posedge clock) begin
    if (!rst_n) begin
      state   <= S_IDLE;
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
      shift   <= 8'h00;
      bit_cnt <= 4'h0;
      byte_no <= 3'd0;
      rw      <= 1'b0;
      gc_mode <= 1'b0;
      msb     <= 8'h00;
      rd_word <= 16'h0000;
      tx_lsb  <= 1'b0;
      sda_oe  <= 1'b0;
      ptr     <= 4'h0;
      wr_stb  <= 1'b0;
      wr_word <= 16'h0000;
      rd_stb  <= 1'b0;
      gc_stb  <= 1'b0;
    end else begin
      scl_q  <= scl;
      sda_q  <= sda_in;
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      gc_stb <= 1'b0;
      if (start_c) begin
        // Start or repeated start restarts the frame
        state   <= S_RX;
        bit_cnt <= 4'h0;
        byte_no <= 3'd0;
        tx_lsb  <= 1'b0;
        sda_oe  <= 1'b0;
      end else if (stop_c) begin
        state  <= S_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (state)
          S_RX: begin
            if (scl_rise) begin
              shift   <= {shift[6:0], sda_in};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == 4'h8) begin
              bit_cnt <= 4'h0;
              state   <= S_ACK;
              sda_oe  <= 1'b1;
              case (byte_no)
                3'd0: begin
                  if (shift[7:1] == target_addr) begin
                    rw      <= shift[0];
                    gc_mode <= 1'b0;
                  end else if (shift == `GEN_CALL_ADDR) begin
                    rw      <= 1'b0;
                    gc_mode <= 1'b1;
                  end else begin
                    // Not ours: stay off the bus until next start
                    state  <= S_IDLE;
                    sda_oe <= 1'b0;
                  end
                end
                3'd1: begin
                  if (gc_mode)
                    gc_stb <= (shift == `GEN_CALL_RESET);
                  else
                    ptr <= shift[3:0];
                end
                3'd2: begin
                  msb <= shift;
                end
                3'd3: begin
                  if (!gc_mode) begin
                    wr_word <= {msb, shift};
                    wr_stb  <= 1'b1;
                  end
                end
                default: begin
                  // Extra bytes are acknowledged and dropped
                end
              endcase
            end
          end
          S_ACK: begin
            if (scl_fall) begin
              if (byte_no != 3'd4)
                byte_no <= byte_no + 3'd1;
              if (rw) begin
                // Present first read bit right after the address ack
                rd_word <= rd_data;
                rd_stb  <= 1'b1;
                sda_oe  <= ~rd_data[15];
                shift   <= {rd_data[14:8], 1'b0};
                tx_lsb  <= 1'b1;
                bit_cnt <= 4'h1;
                state   <= S_TX;
              end else begin
                sda_oe <= 1'b0;
                state  <= S_RX;
              end
            end
          end
          S_TX: begin
            if (scl_fall) begin
              if (bit_cnt == 4'h8) begin
                sda_oe <= 1'b0;
                state  <= S_MACK;
              end else begin
                sda_oe  <= ~shift[7];
                shift   <= {shift[6:0], 1'b0};
                bit_cnt <= bit_cnt + 4'h1;
              end
            end
          end
          S_MACK: begin
            if (scl_rise && sda_in) begin
              // Controller declined more data
              state <= S_IDLE;
            end else if (scl_fall) begin
              bit_cnt <= 4'h1;
              state   <= S_TX;
              if (tx_lsb) begin
                sda_oe <= ~rd_word[7];
                shift  <= {rd_word[6:0], 1'b0};
                tx_lsb <= 1'b0;
              end else begin
                rd_word <= rd_data;
                rd_stb  <= 1'b1;
                sda_oe  <= ~rd_data[15];
                shift   <= {rd_data[14:8], 1'b0};
                tx_lsb  <= 1'b1;
              end
            end
          end
          default: begin
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule

/* hdl/scratch_and_id_registers.v */
// Scratch words, part identifier, averaging and alert behind two-wire bus
//
// Function
// - Second scratch word, free read and write
// - Third scratch word at 07h, resets zero
// - Fourth scratch word at 08h, undefined reset
// - Fourth behaves like first, nonvolatile backed; third reloads zero
// - Read-only part identifier at 0Fh
// - Bus target only; clock line input
// - Averaging of 8, 32 or 64 samples
// - Alert on limit crossing or conversion done
// - Unlock bit makes writes also program storage
// - Second scratch word sits at 06h
`include "sensor_regs_defines.vh"

module scratch_and_id_registers (
  // Clock and reset
  input  wire        clock,
  input  wire        rst_n,
  // Two-wire bus pins
  input  wire        scl,
  input  wire        sda_in,
  output reg         sda_out_ff,
  output reg         sda_oe_ff,
  input  wire [6:0]  target_addr,
  // Temperature samples from the converter
  input  wire        sample_stb,
  input  wire [15:0] sample_in,
  input  wire [1:0]  avg_sel,
  // Alert control and limits
  input  wire        alert_mode,
  input  wire [15:0] high_limit,
  input  wire [15:0] low_limit,
  // Open-drain alert pin
  output reg         alert_out_ff,
  output reg         alert_oe_ff,
  // Status
  output reg         nv_busy_ff,
  output reg         conv_done_ff
);

  // Storage time in clock cycles, at least one. The header gives it as
  // a plain integer, so it is cut to the counter's width on purpose.
  localparam integer PROG_INT = `NV_PROG_CYCLES;
  localparam [15:0]  PROG_LEN = PROG_INT[15:0];

  // Engine outputs. The strobes are one cycle wide and stand with the
  // pointer, so the register side decodes them with no extra stage.
  // The pointer keeps its value between frames for repeated reads.
  wire        sda_oe_c;   // Engine wants the data line low
  wire [3:0]  ptr;        // Current register pointer
  wire        wr_stb;     // Full word written
  wire [15:0] wr_word;    // Written word
  wire        rd_stb;     // Word latched for reading
  wire        gc_stb;     // General-call reset command

  // Read data is combinational, so the engine latches the newest word
  // at the moment it starts shifting a word's upper byte out
  reg  [15:0] rd_data;    // Read mux output

  // Register state. Each scratch word has a logic copy seen by the bus
  // and a storage cell that outlives reset; the two part ways while the
  // word is locked, which is what the unlock bit is for.
  // The arrays are indexed by slot, first word in slot zero.
  reg         unlock_ff;            // Unlock bit, cleared by reset
  reg  [15:0] scratch_ff [0:3];     // Logic copies of scratch words
  reg  [15:0] nv_mem [0:3];         // Nonvolatile cells, never reset
  reg  [15:0] prog_cnt_ff;          // Remaining programming cycles
  reg  [1:0]  prog_idx_ff;          // Cell being programmed
  reg  [15:0] prog_data_ff;         // Word being programmed
  reg         nv_commit;            // Last programming cycle

  // Averaging state. The accumulator holds 64 full-scale signed
  // samples without overflow, so no run wraps before it is scaled.
  // Sum and average are combinational helpers of the clocked process.
  reg  signed [21:0] acc_ff;        // Running sum of samples
  reg  [6:0]  cnt_ff;               // Samples taken in this run
  reg  [1:0]  sel_q_ff;             // Averaging select of this run
  reg  [15:0] result_ff;            // Last averaged result
  reg  signed [21:0] nxt_sum;       // Sum including current sample
  reg  signed [21:0] nxt_avg;       // Scaled average

  // Shift applied for an averaging select. Every count is a power of
  // two, so the average is an arithmetic shift and needs no divider;
  // the single-sample code shifts by zero and passes samples through.
  function [2:0] avg_shift;
    input [1:0] sel;
    begin
      case (sel)
        `AVG_8:  avg_shift = 3'd3;
        `AVG_32: avg_shift = 3'd5;
        `AVG_64: avg_shift = 3'd6;
        default: avg_shift = 3'd0;
      endcase
    end
  endfunction

  // Pointer of a scratch word, and its array slot. The four words sit
  // on consecutive pointers, so the slot is the pointer minus the
  // first one; the write and program paths share both helpers.
  function is_scratch;
    input [3:0] p;
    begin
      is_scratch = (p >= `PTR_SCRATCH_A) && (p <= `PTR_SCRATCH_D);
    end
  endfunction

  function [1:0] slot;
    input [3:0] p;
    reg   [3:0] d;
    begin
      d    = p - `PTR_SCRATCH_A;
      slot = d[1:0];
    end
  endfunction

  // Bus engine: target only, never drives the clock line. Its data line
  // request is registered once more below so the pin comes from a flop;
  // that costs one clock, far inside a bus clock half period.
  twowire_target u_target (
    .clock       (clock),
    .rst_n       (rst_n),
    .scl         (scl),
    .sda_in      (sda_in),
    .sda_oe      (sda_oe_c),
    .target_addr (target_addr),
    .ptr         (ptr),
    .wr_stb      (wr_stb),
    .wr_word     (wr_word),
    .rd_data     (rd_data),
    .rd_stb      (rd_stb),
    .gc_stb      (gc_stb)
  );

  // Read mux; unmapped pointers read zero. The identifier is a
  // constant here, so no bus write can ever reach it.
  // The unlock register shows the busy flag beside the unlock bit,
  // so a host can poll it for the end of a program.
  always @* begin
    rd_data = 16'h0000;
    case (ptr)
      `PTR_RESULT: rd_data = result_ff;
      `PTR_UNLOCK: begin
        rd_data[`UNLOCK_BIT] = unlock_ff;
        rd_data[`BUSY_BIT]   = nv_busy_ff;
      end
      `PTR_SCRATCH_A: rd_data = scratch_ff[0];
      `PTR_SCRATCH_B: rd_data = scratch_ff[1];
      `PTR_SCRATCH_C: rd_data = scratch_ff[2];
      `PTR_SCRATCH_D: rd_data = scratch_ff[3];
      `PTR_PART_ID:   rd_data = `PART_ID_VALUE;
      default:        rd_data = 16'h0000;
    endcase
  end

  // Pin drivers: data line is open drain, the level driven is always low
  // Driving high would fight the pull-up and any other target, so
  // only the enable ever moves; the value stays zero on purpose.
  // Both are registered so the pins never glitch on decode.
  always @(posedge clock) begin
    if (!rst_n) begin
      sda_out_ff <= 1'b0;
      sda_oe_ff  <= 1'b0;
    end else begin
      sda_out_ff <= 1'b0;
      sda_oe_ff  <= sda_oe_c;
    end
  end

  // Register writes and reload from storage on power-up or general call
  // A general call reloads exactly as a reset does; a write strobe in
  // that same cycle is lost, the reload being the stronger request.
  // The unlock bit comes back locked, so a stray write after a
  // reset cannot program storage by accident.
  always @(posedge clock) begin
    if (!rst_n || gc_stb) begin
      unlock_ff     <= `RST_UNLOCK;
      // Reload stored words; the third word always comes up zero
      scratch_ff[0] <= nv_mem[0];
      scratch_ff[1] <= nv_mem[1];
      scratch_ff[2] <= `RST_SCRATCH_C;
      scratch_ff[3] <= nv_mem[3];
    end else if (wr_stb) begin
      if (ptr == `PTR_UNLOCK)
        unlock_ff <= wr_word[`UNLOCK_BIT];
      else if (is_scratch(ptr))
        // Logic copy updates whether locked or not
        scratch_ff[slot(ptr)] <= wr_word;
      // Identifier and unmapped writes fall through untouched
    end
  end

  // Programming sequencer: an unlocked scratch write starts a timed program
  // A write arriving while busy updates the logic copy only; the cell
  // keeps programming the earlier word rather than being cut short.
  // The counter loads the full span; the cell is written through a
  // one-cycle commit pulse as busy drops.
  // A general call does not stop a program under way: a half
  // written cell would be worse than a late reload.
  // Limitation: a host must poll busy before the next stored write.
  always @(posedge clock) begin
    if (!rst_n) begin
      nv_busy_ff   <= 1'b0;
      prog_cnt_ff  <= 16'h0000;
      prog_idx_ff  <= 2'd0;
      prog_data_ff <= 16'h0000;
      nv_commit    <= 1'b0;
    end else begin
      nv_commit <= 1'b0;
      if (nv_busy_ff) begin
        if (prog_cnt_ff == 16'h0001) begin
          nv_busy_ff <= 1'b0;
          nv_commit  <= 1'b1;
        end
        prog_cnt_ff <= prog_cnt_ff - 16'h0001;
      end else if (wr_stb && unlock_ff && is_scratch(ptr)) begin
        nv_busy_ff   <= 1'b1;
        prog_cnt_ff  <= PROG_LEN;
        prog_idx_ff  <= slot(ptr);
        prog_data_ff <= wr_word;
      end
    end
  end

  // Nonvolatile cells survive reset, so this process has no reset branch
  // In simulation they start unknown; a word reads defined only after
  // it has been programmed once. Nothing is cleared here on purpose:
  // stored words are whatever was programmed before.
  always @(posedge clock) begin
    if (nv_commit)
      nv_mem[prog_idx_ff] <= prog_data_ff;
  end

  // Sum and scaled average of the current run. The sample is sign
  // extended before the add so negative readings average correctly,
  // and the arithmetic shift keeps the sign as well.
  // The average is taken from the sum that includes this sample.
  always @* begin
    nxt_sum = acc_ff + {{6{sample_in[15]}}, sample_in};
    nxt_avg = nxt_sum >>> avg_shift(sel_q_ff);
  end

  // Averaging: a changed select restarts the run so no result mixes counts
  // A strobe in the cycle the select changes is dropped with the run.
  // Result and done pulse move together, so a reader never sees the
  // pulse beside an old result.
  always @(posedge clock) begin
    if (!rst_n || gc_stb) begin
      acc_ff       <= 22'sd0;
      cnt_ff       <= 7'd0;
      sel_q_ff     <= avg_sel;
      result_ff    <= `RST_RESULT;
      conv_done_ff <= 1'b0;
    end else begin
      conv_done_ff <= 1'b0;
      if (avg_sel != sel_q_ff) begin
        acc_ff   <= 22'sd0;
        cnt_ff   <= 7'd0;
        sel_q_ff <= avg_sel;
      end else if (sample_stb) begin
        if (cnt_ff + 7'd1 == (7'd1 << avg_shift(sel_q_ff))) begin
          result_ff    <= nxt_avg[15:0];
          acc_ff       <= 22'sd0;
          cnt_ff       <= 7'd0;
          conv_done_ff <= 1'b1;
        end else begin
          acc_ff <= nxt_sum;
          cnt_ff <= cnt_ff + 7'd1;
        end
      end
    end
  end

  // Alert pin: open drain, pulled low while active
  // Both modes act one cycle after the done pulse, once the new
  // result has settled; the window compare is signed like samples.
  // A general call drops the alert along with the averaging run.
  // Limit mode follows the window of the newest result; ready mode holds
  // until the result register is read, and a new result beats the clear.
  always @(posedge clock) begin
    if (!rst_n || gc_stb) begin
      alert_out_ff <= 1'b0;
      alert_oe_ff  <= 1'b0;
    end else begin
      alert_out_ff <= 1'b0;
      if (alert_mode) begin
        if (conv_done_ff)
          alert_oe_ff <= 1'b1;
        else if (rd_stb && ptr == `PTR_RESULT)
          alert_oe_ff <= 1'b0;
      end else if (conv_done_ff) begin
        alert_oe_ff <=
          ($signed(result_ff) > $signed(high_limit)) ||
          ($signed(result_ff) < $signed(low_limit));
      end
    end
  end

endmodule

/* bench/scratch_and_id_registers_props.sv */
// Pin-level checks for the scratch and identifier register block
`include "sensor_regs_defines.vh"
module scratch_and_id_registers_props (
  // Clock and reset
  input wire logic       clock,
  input wire logic       rst_n,
  // Inputs that give cause
  input wire logic       scl,
  input wire logic       sample_stb,
  input wire logic [1:0] avg_sel,
  input wire logic       alert_mode,
  // Outputs under watch
  input wire logic       sda_out_ff,
  input wire logic       sda_oe_ff,
  input wire logic       alert_out_ff,
  input wire logic       alert_oe_ff,
  input wire logic       nv_busy_ff,
  input wire logic       conv_done_ff
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int NV_CYC = `NV_PROG_CYCLES; // Programming length
  logic [15:0] busy_cnt; // Cycles spent programming so far
  logic [7:0]  stb_cnt;  // Strobes not yet consumed by a result
  logic [7:0]  avg_n;    // Strobes expected per result
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Samples per result for the select code in force
  assign avg_n = (avg_sel == 2'b00) ? 8'h01 : (avg_sel == 2'b01) ? 8'h08 :
                 (avg_sel == 2'b10) ? 8'h20 : 8'h40;
  // Busy span counter, cleared whenever busy is low
  always_ff @(posedge clock) begin
    if (!rst_n || !nv_busy_ff) busy_cnt <= 16'h0000;
    else busy_cnt <= busy_cnt + 16'h0001;
  end
  // Strobe balance; a select change restarts the run, so it clears too
  always_ff @(posedge clock) begin
    if (!rst_n || $changed(avg_sel)) stb_cnt <= 8'h00;
    else stb_cnt <= stb_cnt + {7'h00, sample_stb} -
                    (conv_done_ff ? avg_n : 8'h00);
  end
  a_sda_pull_only: assert property (sda_out_ff == 1'b0)
    else $error("data line driven high");
  a_sda_scl_low: assert property ($changed(sda_oe_ff) |-> !$past(scl))
    else $error("data line moved while bus clock high");
  a_alert_pull_only: assert property (alert_out_ff == 1'b0)
    else $error("alert driven high");
  a_alert_on_ready: assert property (alert_mode && conv_done_ff |=>
    alert_oe_ff) else $error("ready alert missing");
  a_alert_held: assert property (!alert_mode && !conv_done_ff |=>
    $stable(alert_oe_ff)) else $error("window alert moved without result");
  a_busy_span: assert property ($fell(nv_busy_ff) |->
    busy_cnt == NV_CYC) else $error("programming span wrong");
  a_done_count: assert property (conv_done_ff |-> stb_cnt == avg_n)
    else $error("result after wrong sample count");
  a_done_follows: assert property (conv_done_ff |-> $past(sample_stb))
    else $error("result not right after a strobe");
  a_reset_quiet: assert property (disable iff (1'b0) !rst_n |=>
    !sda_oe_ff && !alert_oe_ff && !nv_busy_ff && !conv_done_ff)
    else $error("outputs active after reset");
endmodule
bind scratch_and_id_registers scratch_and_id_registers_props i_props (
  .clock(clock), .rst_n(rst_n), .scl(scl), .sample_stb(sample_stb),
  .avg_sel(avg_sel), .alert_mode(alert_mode), .sda_out_ff(sda_out_ff),
  .sda_oe_ff(sda_oe_ff), .alert_out_ff(alert_out_ff),
  .alert_oe_ff(alert_oe_ff), .nv_busy_ff(nv_busy_ff),
  .conv_done_ff(conv_done_ff));

/* bench/bus_controller_model.sv */
// Behavioural two-wire bus controller that talks to the target
module bus_controller_model #(
  parameter logic [6:0] TGT = 7'h48 // Target address, arbitrary
) (
  // Clock
  input  wire logic clock,
  // Bus pins
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] acks; // Acks of the last four bytes sent, newest in bit 0
  // Bus idles high
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    acks = 4'h0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask
  // One bit slot, 6 clocks low and 6 high; data moves only while low
  task automatic slot(input logic v, output logic s);
    wt(3);
    sda_low <= ~v;
    wt(3);
    scl <= 1'b1;
    wt(3);
    s = sda;
    wt(3);
    scl <= 1'b0;
  endtask
  // Start, also usable as repeated start
  task automatic start_c;
    wt(3);
    sda_low <= 1'b0;
    wt(3);
    scl <= 1'b1;
    wt(6);
    sda_low <= 1'b1;
    wt(6);
    scl <= 1'b0;
  endtask
  task automatic stop_c;
    wt(3);
    sda_low <= 1'b1;
    wt(3);
    scl <= 1'b1;
    wt(6);
    sda_low <= 1'b0;
    wt(6);
  endtask
  // Byte out, MSB first, then release for the target's ack
  task automatic tx(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) slot(b[i], s);
    slot(1'b1, s);
    acks = {acks[2:0], ~s};
  endtask
  // Byte in; last byte gets a not-acknowledge
  task automatic rx(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 0; i < 8; i++) begin
      slot(1'b1, s);
      b = {b[6:0], s};
    end
    slot(last, s);
  endtask
  task automatic wr(input logic [3:0] p, input logic [15:0] d);
    start_c;
    tx({TGT, 1'b0});
    tx({4'h0, p});
    tx(d[15:8]);
    tx(d[7:0]);
    stop_c;
  endtask
  task automatic rd(input logic [3:0] p, output logic [15:0] d);
    logic [7:0] hi;
    logic [7:0] lo;
    start_c;
    tx({TGT, 1'b0});
    tx({4'h0, p});
    start_c;
    tx({TGT, 1'b1});
    rx(1'b0, hi);
    rx(1'b1, lo);
    stop_c;
    d = {hi, lo};
  endtask
  // Two raw bytes, for general call and foreign addresses
  task automatic raw(input logic [7:0] a, input logic [7:0] b);
    start_c;
    tx(a);
    tx(b);
    stop_c;
  endtask
endmodule

/* bench/scratch_and_id_registers_tb_top.sv */
// Self-checking bench for the scratch and identifier register block
`include "sensor_regs_defines.vh"
module scratch_and_id_registers_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [6:0] TGT = 7'h48;        // Bus address, arbitrary
  localparam int NS [4] = '{1, 8, 32, 64};   // Samples per select code
  localparam logic [15:0] AV [3] = '{16'h0200, 16'hFE00, 16'h0050};
  // Clock, reset and bus
  logic        clock, rst_n, scl, host_low, sda;
  // Converter and alert inputs
  logic        sample_stb, alert_mode;
  logic [15:0] sample_in, high_limit, low_limit, d;
  logic [1:0]  avg_sel;
  // Design outputs
  logic        sda_out_ff, sda_oe_ff, alert_out_ff, alert_oe_ff;
  logic        nv_busy_ff, conv_done_ff;
  int          fails, cmp_count, done_n, i;
  // Data line with pull-up, low if either party pulls
  assign sda = (sda_oe_ff ? sda_out_ff : 1'b1) & ~host_low;
  scratch_and_id_registers i_dut (
    .clock(clock), .rst_n(rst_n), .scl(scl), .sda_in(sda),
    .sda_out_ff(sda_out_ff), .sda_oe_ff(sda_oe_ff), .target_addr(TGT),
    .sample_stb(sample_stb), .sample_in(sample_in), .avg_sel(avg_sel),
    .alert_mode(alert_mode), .high_limit(high_limit),
    .low_limit(low_limit), .alert_out_ff(alert_out_ff),
    .alert_oe_ff(alert_oe_ff), .nv_busy_ff(nv_busy_ff),
    .conv_done_ff(conv_done_ff));
  bus_controller_model #(.TGT(TGT)) i_host (
    .clock(clock), .sda(sda), .scl(scl), .sda_low(host_low));
  // 50 ns clock
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // Count result pulses seen
  always @(posedge clock) begin
    if (conv_done_ff === 1'b1) done_n <= done_n + 1;
  end
  task automatic check(input string nm, input logic [15:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // n strobes alternating around v, so the mean is exactly v
  task automatic samples(input int n, input logic [15:0] v);
    for (int k = 0; k < n; k++) begin
      @(posedge clock);
      sample_stb <= 1'b1;
      sample_in <= (n == 1) ? v : (k[0] ? v + 16'h0010 : v - 16'h0010);
      @(posedge clock);
      sample_stb <= 1'b0;
    end
    repeat (3) @(posedge clock);
  endtask
  // Watchdog, well beyond the roughly 13k cycles the run needs
  initial begin
    #2000000;
    fails++;
    print_verdict;
  end
  initial begin
    rst_n = 1'b0;
    sample_stb = 1'b0;
    sample_in = 16'h0000;
    avg_sel = 2'b00;
    alert_mode = 1'b0;
    high_limit = 16'h0100;
    low_limit = 16'hFF00;
    fails = 0;
    cmp_count = 0;
    done_n = 0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    i_host.rd(4'h7, d);
    check("scratch_c reset", d, `RST_SCRATCH_C);
    i_host.rd(4'hF, d);
    check("part_identifier", d, `PART_ID_VALUE);
    i_host.wr(4'hF, 16'h1234);
    check("id write acks", {12'h000, i_host.acks}, 16'h000F);
    i_host.rd(4'hF, d);
    check("part_identifier kept", d, `PART_ID_VALUE);
    i_host.raw({TGT ^ 7'h01, 1'b0}, 8'h00);
    check("foreign acks", {14'h0, i_host.acks[1:0]}, 16'h0000);
    for (i = 6; i < 9; i++) begin
      i_host.wr(i[3:0], 16'hC3A0 + i[15:0]);
      i_host.rd(i[3:0], d);
      check("scratch word", d, 16'hC3A0 + i[15:0]);
    end
    // Unlocked write programs storage, locked one only the logic copy
    i_host.wr(4'h4, 16'h8000);
    i_host.wr(4'h8, 16'hD00D);
    check("busy unlocked", {15'h0, nv_busy_ff}, 16'h0001);
    for (i = 0; i < 300 && nv_busy_ff !== 1'b0; i++) @(posedge clock);
    i_host.wr(4'h4, 16'h0000);
    i_host.wr(4'h8, 16'h1111);
    check("busy locked", {15'h0, nv_busy_ff}, 16'h0000);
    i_host.rd(4'h8, d);
    check("scratch_d logic copy", d, 16'h1111);
    i_host.raw(`GEN_CALL_ADDR, `GEN_CALL_RESET);
    repeat (8) @(posedge clock);
    i_host.rd(4'h8, d);
    check("scratch_d reload", d, 16'hD00D);
    i_host.rd(4'h7, d);
    check("scratch_c reload", d, `RST_SCRATCH_C);
    // Every averaging code
    for (i = 0; i < 4; i++) begin
      avg_sel <= i[1:0];
      samples(NS[i], 16'h0020 + i[15:0]);
      i_host.rd(4'h0, d);
      check("averaged result", d, 16'h0020 + i[15:0]);
      check("result count", done_n[15:0], i[15:0] + 16'h0001);
    end
    // Window alert: above, below, then inside the limits
    avg_sel <= 2'b00;
    for (i = 0; i < 3; i++) begin
      samples(1, AV[i]);
      check("window alert", {15'h0, alert_oe_ff},
            (i < 2) ? 16'h0001 : 16'h0000);
    end
    // Ready alert, cleared by reading the result
    alert_mode <= 1'b1;
    samples(1, 16'h0010);
    check("ready alert", {15'h0, alert_oe_ff}, 16'h0001);
    i_host.rd(4'h0, d);
    check("ready alert cleared", {15'h0, alert_oe_ff}, 16'h0000);
    print_verdict;
  end
endmodule
